// ---- design/overlay_params.svh ----
// Offsets, field positions, reset values and widths of the overlay buffer select block
// Assumes a 16-bit byte address taken from the low AXI4-Lite address bits
`ifndef OVERLAY_PARAMS_SVH
`define OVERLAY_PARAMS_SVH

// Register byte offsets
`define OFS_PRI_START0   16'h81c0
`define OFS_PRI_START1   16'h81c4
`define OFS_DBL_SELECT   16'h81cc
`define OFS_SEC_START0   16'h81d0
`define OFS_SEC_START1   16'h81d4
`define OFS_SEC_STRIDE   16'h81d8
`define OFS_SKIP_CTRL    16'h81dc
`define OFS_SCALE_SECOND 16'h81e4
`define OFS_ACCUM_INIT   16'h81e8
`define OFS_PRI_WIN      16'h81f0
`define OFS_SCALE_FIRST  16'h8150

// Widths
`define BUS_ADDR_W 16
`define START_W    22
`define STRIDE_W   12
`define QW_W       10
`define SCALE_W    11
`define ACCUM_W    12

// Select register fields
`define SEL_PRI_BIT    0
`define SEL_SEC_LO     1
`define SEL_SEC_HI     2
`define SEL_IN_BIT     4
`define SEL_LATCH_BIT  5
`define SEL_TOGGLE_BIT 6

// Fetch skip register fields
`define SKIP_STOP_LO   3
`define SKIP_STOP_HI   12
`define SKIP_RESUME_LO 19
`define SKIP_RESUME_HI 28
`define SKIP_TOP_BIT   30
`define SKIP_EN_BIT    31

// Window start field mask and reset values
`define PRI_WIN_MASK  32'h07ff_07ff
`define RESET_WORD    32'h0000_0000

// Compose modes with an opaque top window
`define COMPOSE_SEC_ON_PRI 3'h0
`define COMPOSE_PRI_ON_SEC 3'h1

// AXI responses
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- design/overlay_pkg.sv ----
// Types of the overlay buffer select block
// Assumes overlay_params.svh is on the include path
`include "overlay_params.svh"

package overlay_pkg;

  typedef enum logic [1:0] {
    SEC_FIXED0  = 2'b00,
    SEC_FIXED1  = 2'b01,
    SEC_PAIRED  = 2'b10,
    SEC_PINGPONG = 2'b11
  } sec_mode_type;

  typedef struct packed {
    logic [`START_W-1:0]    pri_start0;
    logic [`START_W-1:0]    pri_start1;
    logic [`START_W-1:0]    sec_start0;
    logic [`START_W-1:0]    sec_start1;
    logic [`STRIDE_W-1:0]   sec_stride;
    logic                   pri_sel;
    sec_mode_type           sec_sel;
    logic                   in_sel;
    logic                   in_pending;
    logic                   in_pending_val;
    logic                   latch_mode;
    logic                   toggle_mode;
    logic [`QW_W-1:0]       skip_stop;
    logic [`QW_W-1:0]       skip_resume;
    logic                   top_sel;
    logic                   skip_en;
    logic [31:0]            pri_win;
    logic [`SCALE_W-1:0]    k1_prog;
    logic [`SCALE_W-1:0]    k2_prog;
    logic [`ACCUM_W-1:0]    acc_prog;
    logic [`SCALE_W-1:0]    k1_act;
    logic [`SCALE_W-1:0]    k2_act;
    logic [`ACCUM_W-1:0]    acc_act;
    logic [`START_W-1:0]    pri_addr;
    logic [`START_W-1:0]    sec_addr;
    logic                   skip_active;
    logic                   aw_held;
    logic [`BUS_ADDR_W-1:0] aw_addr;
    logic                   w_held;
    logic [31:0]            w_data;
    logic [3:0]             w_strb;
    logic                   awready;
    logic                   wready;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
  } state_type;

endpackage

// ---- design/overlay_buffer_select_and_scaling_regs.sv ----
// Overlay buffer select, fetch skip and vertical scaling registers behind AXI4-Lite
// Assumes frame end and vertical sync arrive as one-cycle pulses synchronous to aclk
`timescale 1ns/10ps
`default_nettype none
`include "overlay_params.svh"

module overlay_buffer_select_and_scaling_regs
  import overlay_pkg::*;
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [`BUS_ADDR_W-1:0] awaddr,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  input  wire logic [`BUS_ADDR_W-1:0] araddr,
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  input  wire logic                   input_frame_end,
  input  wire logic                   vsync,
  input  wire logic [2:0]             compose_mode,
  output logic [`START_W-1:0]         primary_fetch_start,
  output logic [`START_W-1:0]         secondary_fetch_start,
  output logic [`STRIDE_W-1:0]        secondary_stride,
  output logic                        input_buffer_select,
  output logic                        fetch_skip_active,
  output logic                        top_window_select,
  output logic [`QW_W-1:0]            skip_stop_qw,
  output logic [`QW_W-1:0]            skip_resume_qw,
  output logic [`SCALE_W-1:0]         first_scale_constant,
  output logic [`SCALE_W-1:0]         second_scale_constant,
  output logic [`ACCUM_W-1:0]         scaling_accumulator_init
);

  state_type st_ff;
  state_type nxt_st;
  logic      sel_write;

  // Byte lane merge of a write into the current word
  function automatic logic [31:0] lane_merge(input logic [31:0] old_word,
                                             input logic [31:0] new_word,
                                             input logic [3:0]  strb);
    logic [31:0] merged;
    merged = old_word;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merged[8*i +: 8] = new_word[8*i +: 8];
      end
    end
    return merged;
  endfunction

  // Register readback; top bit flags a mapped address
  function automatic logic [32:0] reg_read(input state_type s,
                                           input logic [`BUS_ADDR_W-1:0] a);
    logic [32:0] r;
    r = {1'b1, `RESET_WORD};
    unique case (a)
      `OFS_PRI_START0:   r[`START_W-1:0] = s.pri_start0;
      `OFS_PRI_START1:   r[`START_W-1:0] = s.pri_start1;
      `OFS_SEC_START0:   r[`START_W-1:0] = s.sec_start0;
      `OFS_SEC_START1:   r[`START_W-1:0] = s.sec_start1;
      `OFS_SEC_STRIDE:   r[`STRIDE_W-1:0] = s.sec_stride;
      `OFS_DBL_SELECT: begin
        r[`SEL_PRI_BIT]                = s.pri_sel;
        r[`SEL_SEC_HI:`SEL_SEC_LO]     = s.sec_sel;
        r[`SEL_IN_BIT]                 = s.in_sel;
        r[`SEL_LATCH_BIT]              = s.latch_mode;
        r[`SEL_TOGGLE_BIT]             = s.toggle_mode;
      end
      `OFS_SKIP_CTRL: begin
        r[`SKIP_STOP_HI:`SKIP_STOP_LO]     = s.skip_stop;
        r[`SKIP_RESUME_HI:`SKIP_RESUME_LO] = s.skip_resume;
        r[`SKIP_TOP_BIT]                   = s.top_sel;
        r[`SKIP_EN_BIT]                    = s.skip_en;
      end
      `OFS_SCALE_FIRST:  r[`SCALE_W-1:0] = s.k1_prog;
      `OFS_SCALE_SECOND: r[`SCALE_W-1:0] = s.k2_prog;
      `OFS_ACCUM_INIT:   r[`ACCUM_W-1:0] = s.acc_prog;
      `OFS_PRI_WIN:      r[31:0] = s.pri_win;
      default:           r[32] = 1'b0;
    endcase
    return r;
  endfunction

  // Secondary buffer index from select mode and input buffer
  function automatic logic sec_index(input sec_mode_type mode, input logic in_sel);
    logic idx;
    unique case (mode)
      SEC_FIXED0:   idx = 1'b0;
      SEC_FIXED1:   idx = 1'b1;
      SEC_PAIRED:   idx = in_sel;
      SEC_PINGPONG: idx = ~in_sel;
    endcase
    return idx;
  endfunction

  // Next state: bus handshakes, register writes, frame end and vsync updates
  always_comb begin
    logic [32:0] rd;
    logic [31:0] m;
    rd = 33'h0_0000_0000;
    m = `RESET_WORD;
    nxt_st = st_ff;
    sel_write = 1'b0;
    // Address and data are taken in either order
    if (awvalid && st_ff.awready) begin
      nxt_st.aw_held = 1'b1;
      nxt_st.aw_addr = awaddr;
    end
    if (wvalid && st_ff.wready) begin
      nxt_st.w_held = 1'b1;
      nxt_st.w_data = wdata;
      nxt_st.w_strb = wstrb;
    end
    if (st_ff.bvalid && bready) begin
      nxt_st.bvalid = 1'b0;
    end
    // Frame end applies a deferred select, else toggles in toggle mode
    if (input_frame_end) begin
      if (st_ff.in_pending) begin
        nxt_st.in_sel = st_ff.in_pending_val;
        nxt_st.in_pending = 1'b0;
      end else if (st_ff.toggle_mode) begin
        nxt_st.in_sel = ~st_ff.in_sel;
      end
    end
    // Scale constants move to the active copy at vertical sync
    if (vsync) begin
      nxt_st.k1_act = st_ff.k1_prog;
      nxt_st.k2_act = st_ff.k2_prog;
      nxt_st.acc_act = st_ff.acc_prog;
    end
    // Write once both halves are held; a write beats a same-cycle frame end
    if (st_ff.aw_held && st_ff.w_held && !st_ff.bvalid) begin
      rd = reg_read(st_ff, st_ff.aw_addr);
      m = lane_merge(rd[31:0], st_ff.w_data, st_ff.w_strb);
      nxt_st.aw_held = 1'b0;
      nxt_st.w_held = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = rd[32] ? `RESP_OKAY : `RESP_SLVERR;
      unique case (st_ff.aw_addr)
        `OFS_PRI_START0:   nxt_st.pri_start0 = m[`START_W-1:0];
        `OFS_PRI_START1:   nxt_st.pri_start1 = m[`START_W-1:0];
        `OFS_SEC_START0:   nxt_st.sec_start0 = m[`START_W-1:0];
        `OFS_SEC_START1:   nxt_st.sec_start1 = m[`START_W-1:0];
        `OFS_SEC_STRIDE:   nxt_st.sec_stride = m[`STRIDE_W-1:0];
        `OFS_DBL_SELECT: begin
          sel_write = 1'b1;
          nxt_st.pri_sel = m[`SEL_PRI_BIT];
          nxt_st.sec_sel = sec_mode_type'(m[`SEL_SEC_HI:`SEL_SEC_LO]);
          nxt_st.latch_mode = m[`SEL_LATCH_BIT];
          nxt_st.toggle_mode = m[`SEL_TOGGLE_BIT];
          if (m[`SEL_LATCH_BIT]) begin
            nxt_st.in_pending = 1'b1;
            nxt_st.in_pending_val = m[`SEL_IN_BIT];
          end else begin
            nxt_st.in_pending = 1'b0;
            nxt_st.in_sel = m[`SEL_IN_BIT];
          end
        end
        `OFS_SKIP_CTRL: begin
          nxt_st.skip_stop = m[`SKIP_STOP_HI:`SKIP_STOP_LO];
          nxt_st.skip_resume = m[`SKIP_RESUME_HI:`SKIP_RESUME_LO];
          nxt_st.top_sel = m[`SKIP_TOP_BIT];
          nxt_st.skip_en = m[`SKIP_EN_BIT];
        end
        `OFS_SCALE_FIRST:  nxt_st.k1_prog = m[`SCALE_W-1:0];
        `OFS_SCALE_SECOND: nxt_st.k2_prog = m[`SCALE_W-1:0];
        `OFS_ACCUM_INIT:   nxt_st.acc_prog = m[`ACCUM_W-1:0];
        `OFS_PRI_WIN:      nxt_st.pri_win = m & `PRI_WIN_MASK;
        default: begin
        end
      endcase
    end
    // Read answer one cycle after the address is taken
    if (st_ff.rvalid && rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (arvalid && st_ff.arready) begin
      rd = reg_read(st_ff, araddr);
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = rd[31:0];
      nxt_st.rresp = rd[32] ? `RESP_OKAY : `RESP_SLVERR;
    end
    nxt_st.awready = ~nxt_st.aw_held & ~nxt_st.bvalid;
    nxt_st.wready = ~nxt_st.w_held & ~nxt_st.bvalid;
    nxt_st.arready = ~nxt_st.rvalid;
    // Fetch side outputs follow the new state
    nxt_st.pri_addr = nxt_st.pri_sel ? nxt_st.pri_start1 : nxt_st.pri_start0;
    nxt_st.sec_addr = sec_index(nxt_st.sec_sel, nxt_st.in_sel) ?
                      nxt_st.sec_start1 : nxt_st.sec_start0;
    // Skip only in the two opaque compose modes
    nxt_st.skip_active = nxt_st.skip_en &&
                         (compose_mode == `COMPOSE_SEC_ON_PRI ||
                          compose_mode == `COMPOSE_PRI_ON_SEC);
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign awready = st_ff.awready;
  assign wready = st_ff.wready;
  assign bvalid = st_ff.bvalid;
  assign bresp = st_ff.bresp;
  assign arready = st_ff.arready;
  assign rvalid = st_ff.rvalid;
  assign rdata = st_ff.rdata;
  assign rresp = st_ff.rresp;
  assign primary_fetch_start = st_ff.pri_addr;
  assign secondary_fetch_start = st_ff.sec_addr;
  assign secondary_stride = st_ff.sec_stride;
  assign input_buffer_select = st_ff.in_sel;
  assign fetch_skip_active = st_ff.skip_active;
  assign top_window_select = st_ff.top_sel;
  assign skip_stop_qw = st_ff.skip_stop;
  assign skip_resume_qw = st_ff.skip_resume;
  assign first_scale_constant = st_ff.k1_act;
  assign second_scale_constant = st_ff.k2_act;
  assign scaling_accumulator_init = st_ff.acc_act;

  // Checks on the fetch side and the bus answers
  sequence write_done_s;
    st_ff.aw_held && st_ff.w_held && !st_ff.bvalid;
  endsequence

  sequence frame_toggle_s;
    input_frame_end && st_ff.toggle_mode && !st_ff.in_pending && !sel_write;
  endsequence

  sequence frame_apply_s;
    input_frame_end && st_ff.in_pending && !sel_write;
  endsequence

  sequence read_taken_s;
    arvalid && arready;
  endsequence

  pri_start_pick_a: assert property (@(posedge aclk) disable iff (!aresetn)
    primary_fetch_start == (st_ff.pri_sel ? st_ff.pri_start1 : st_ff.pri_start0))
    else $error("primary fetch start does not follow its select");

  sec_fixed_pick_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st_ff.sec_sel == SEC_FIXED1 |-> secondary_fetch_start == st_ff.sec_start1)
    else $error("secondary fixed select picked the wrong buffer");

  sec_fixed0_pick_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st_ff.sec_sel == SEC_FIXED0 |-> secondary_fetch_start == st_ff.sec_start0)
    else $error("secondary fixed select 0 picked the wrong buffer");

  sec_paired_pick_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st_ff.sec_sel == SEC_PAIRED |->
      secondary_fetch_start == (input_buffer_select ? st_ff.sec_start1 : st_ff.sec_start0))
    else $error("paired secondary buffer does not match input buffer");

  sec_pingpong_pick_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st_ff.sec_sel == SEC_PINGPONG |->
      secondary_fetch_start == (input_buffer_select ? st_ff.sec_start0 : st_ff.sec_start1))
    else $error("ping-pong secondary buffer not opposite input buffer");

  frame_toggle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_toggle_s |=> input_buffer_select != $past(input_buffer_select))
    else $error("input select did not toggle at frame end");

  latch_defer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    st_ff.in_pending && !input_frame_end && !sel_write |=> $stable(input_buffer_select))
    else $error("deferred input select applied before frame end");

  latch_apply_a: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_apply_s |=> input_buffer_select == $past(st_ff.in_pending_val))
    else $error("deferred input select not applied at frame end");

  pending_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_apply_s |=> !st_ff.in_pending)
    else $error("deferred input select still pending after frame end");

  toggle_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    input_frame_end && !st_ff.toggle_mode && !st_ff.in_pending && !sel_write |=>
      $stable(input_buffer_select))
    else $error("input select changed at frame end with toggle off");

  scale_vsync_a: assert property (@(posedge aclk) disable iff (!aresetn)
    vsync |=> first_scale_constant == $past(st_ff.k1_prog) &&
              second_scale_constant == $past(st_ff.k2_prog))
    else $error("scale constants not taken at vertical sync");

  scale_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !vsync |=> $stable(second_scale_constant) && $stable(scaling_accumulator_init))
    else $error("scale constants changed without vertical sync");

  first_scale_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !vsync |=> $stable(first_scale_constant))
    else $error("first scale constant changed without vertical sync");

  accum_vsync_a: assert property (@(posedge aclk) disable iff (!aresetn)
    vsync |=> scaling_accumulator_init == $past(st_ff.acc_prog))
    else $error("accumulator initial value not taken at vertical sync");

  skip_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    fetch_skip_active == (st_ff.skip_en &&
                          ($past(compose_mode) == `COMPOSE_SEC_ON_PRI ||
                           $past(compose_mode) == `COMPOSE_PRI_ON_SEC)))
    else $error("fetch skip does not follow enable and compose mode");

  skip_fields_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !(st_ff.aw_held && st_ff.w_held && !st_ff.bvalid) |=>
      $stable(skip_stop_qw) && $stable(skip_resume_qw) && $stable(top_window_select))
    else $error("fetch skip fields changed without a register write");

  stride_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !(st_ff.aw_held && st_ff.w_held && !st_ff.bvalid) |=> $stable(secondary_stride))
    else $error("secondary stride changed without a register write");

  // Bus answers come in time, stand until taken and block new requests
  write_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    write_done_s |=> bvalid)
    else $error("write answer missing after the write");

  bvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped before it was taken");

  write_refuse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid |-> !awready && !wready)
    else $error("write channels ready while an answer is pending");

  read_answer_a: assert property (@(posedge aclk) disable iff (!aresetn)
    read_taken_s |=> rvalid)
    else $error("read answer missing one cycle after the address");

  rvalid_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer changed before it was taken");

  read_refuse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid |-> !arready)
    else $error("read address ready while an answer is pending");

endmodule
`default_nettype wire

// ---- design/_unused_guard.sv ----
// Intentionally empty module-free file is not needed

// ---- sim/video_side_model.sv ----
// Model of the display fetch engine and the video input writer
// Assumes the testbench calls its tasks from a process synced to aclk
`timescale 1ns/10ps
`default_nettype none

module video_side_model (
  input  wire logic      aclk,
  output var  logic      input_frame_end,
  output var  logic      vsync,
  output var  logic [2:0] compose_mode
);

  // Idle levels at time zero
  initial begin
    input_frame_end = 1'b0;
    vsync           = 1'b0;
    compose_mode    = 3'h0;
  end

  // One-cycle end of input frame pulse
  task automatic frame_end;
    @(posedge aclk);
    input_frame_end <= 1'b1;
    @(posedge aclk);
    input_frame_end <= 1'b0;
  endtask

  // One-cycle vertical sync pulse
  task automatic vsync_pulse;
    @(posedge aclk);
    vsync <= 1'b1;
    @(posedge aclk);
    vsync <= 1'b0;
  endtask

  // Blend compose mode, held as a level
  task automatic set_mode(input logic [2:0] m);
    @(posedge aclk);
    compose_mode <= m;
  endtask

endmodule

`default_nettype wire

// ---- sim/tb_overlay_buffer_select_and_scaling_regs.sv ----
// Self-checking bench for the overlay buffer select and scaling registers
// Assumes overlay_params.svh on the include path and the far-side model beside it
`timescale 1ns/10ps
`default_nettype none
`include "overlay_params.svh"

module tb_overlay_buffer_select_and_scaling_regs;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [15:0] awaddr = 16'h0000;
  logic        awvalid = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic [15:0] araddr = 16'h0000;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        frame_end, vsync, in_sel, skip_act, top_sel;
  logic [2:0]  mode;
  logic [21:0] pri_start, sec_start;
  logic [11:0] stride, acc_init;
  logic [9:0]  stop_qw, resume_qw;
  logic [10:0] k1, k2;
  int          n_mismatch = 0;
  int          checks_done = 0;
  logic [21:0] starts[4] = '{22'h01_2340, 22'h02_5680, 22'h03_9ac0, 22'h00_def8};
  logic [15:0] addrs[9] = '{`OFS_PRI_START0, `OFS_SEC_START0, `OFS_SEC_START1,
    `OFS_SEC_STRIDE, `OFS_SKIP_CTRL, `OFS_SCALE_FIRST, `OFS_SCALE_SECOND,
    `OFS_ACCUM_INIT, `OFS_PRI_WIN};
  logic [31:0] masks[9] = '{32'h003f_fff8, 32'h003f_fff8, 32'h003f_fff8, 32'h0000_0fff,
    32'hdff8_1ff8, 32'h0000_07ff, 32'h0000_07ff, 32'h0000_0fff, 32'h07ff_07ff};
  logic [31:0] sel;

  always #10 aclk = ~aclk;

  overlay_buffer_select_and_scaling_regs dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .input_frame_end(frame_end), .vsync(vsync), .compose_mode(mode),
    .primary_fetch_start(pri_start), .secondary_fetch_start(sec_start),
    .secondary_stride(stride), .input_buffer_select(in_sel),
    .fetch_skip_active(skip_act), .top_window_select(top_sel), .skip_stop_qw(stop_qw),
    .skip_resume_qw(resume_qw), .first_scale_constant(k1), .second_scale_constant(k2),
    .scaling_accumulator_init(acc_init));

  video_side_model partner (
    .aclk(aclk), .input_frame_end(frame_end), .vsync(vsync), .compose_mode(mode));

  // Compare one value and count it
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Register write; address and data offered together, each released when taken
  task automatic axi_write(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1 && awvalid) awvalid <= 1'b0;
      if (wready === 1'b1 && wvalid) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    check(32'(bresp), 32'(er));
  endtask

  // Register read with expected data and response
  task automatic axi_read(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1 && arvalid) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    check(rdata, ed);
    check(32'(rresp), 32'(er));
  endtask

  // Frame end pulse, then let the registered outputs land
  task automatic frame_step;
    partner.frame_end();
    @(posedge aclk);
  endtask

  task automatic print_verdict;
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles the tests take
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Reset values, writable bits and vsync-latched scale constants
    for (int i = 0; i < 9; i++) axi_read(addrs[i], 32'h0000_0000, `RESP_OKAY);
    for (int i = 0; i < 9; i++) begin
      axi_write(addrs[i], masks[i], `RESP_OKAY);
      axi_read(addrs[i], masks[i], `RESP_OKAY);
    end
    check(32'({k1, k2}), 32'h0000_0000);
    check(32'(acc_init), 32'h0000_0000);
    check(32'(stride), 32'h0000_0fff);
    partner.vsync_pulse();
    @(posedge aclk);
    check(32'({k1, k2}), 32'h003f_ffff);
    check(32'(acc_init), 32'h0000_0fff);
    axi_write(16'h8100, 32'h1234_5678, `RESP_SLVERR);
    axi_read(16'h8100, 32'h0000_0000, `RESP_SLVERR);
    // Buffer start addresses and every select combination
    axi_write(`OFS_PRI_START0, 32'(starts[0]), `RESP_OKAY);
    axi_write(`OFS_PRI_START1, 32'(starts[1]), `RESP_OKAY);
    axi_write(`OFS_SEC_START0, 32'(starts[2]), `RESP_OKAY);
    axi_write(`OFS_SEC_START1, 32'(starts[3]), `RESP_OKAY);
    for (int v = 0; v < 16; v++) begin
      sel = {27'h0, v[3], 1'b0, v[2:1], v[0]};
      axi_write(`OFS_DBL_SELECT, sel, `RESP_OKAY);
      check(32'(pri_start), 32'(starts[v[0]]));
      check(32'(sec_start), 32'(starts[2 + ((v[2:1] == 2'b00) ? 0 : (v[2:1] == 2'b01) ? 1 :
        (v[2:1] == 2'b10) ? v[3] : 32'(!v[3]))]));
      check(32'(in_sel), 32'(v[3]));
      axi_read(`OFS_DBL_SELECT, sel, `RESP_OKAY);
    end
    // Deferred select, then toggling with ping-pong display
    axi_write(`OFS_DBL_SELECT, 32'h0000_0000, `RESP_OKAY);
    axi_write(`OFS_DBL_SELECT, 32'h0000_0030, `RESP_OKAY);
    check(32'(in_sel), 32'h0000_0000);
    axi_read(`OFS_DBL_SELECT, 32'h0000_0020, `RESP_OKAY);
    frame_step();
    check(32'(in_sel), 32'h0000_0001);
    axi_write(`OFS_DBL_SELECT, 32'h0000_0046, `RESP_OKAY);
    check(32'({in_sel, sec_start}), 32'(starts[3]));
    frame_step();
    check(32'({in_sel, sec_start}), {9'h0, 1'b1, starts[2]});
    frame_step();
    check(32'(in_sel), 32'h0000_0000);
    axi_write(`OFS_DBL_SELECT, 32'h0000_0000, `RESP_OKAY);
    frame_step();
    check(32'(in_sel), 32'h0000_0000);
    // Fetch skip window, top select and compose modes
    axi_write(`OFS_SKIP_CTRL, {2'b11, 1'b0, 10'h2aa, 6'h00, 10'h155, 3'h0}, `RESP_OKAY);
    check(32'({top_sel, resume_qw, stop_qw}), 32'h001a_a955);
    for (int m = 0; m < 8; m++) begin
      partner.set_mode(3'(m));
      repeat (2) @(posedge aclk);
      check(32'(skip_act), 32'(m < 2));
    end
    partner.set_mode(3'h1);
    axi_write(`OFS_SKIP_CTRL, 32'h0000_1550, `RESP_OKAY);
    repeat (2) @(posedge aclk);
    check(32'({skip_act, top_sel, stop_qw}), 32'h0000_02aa);
    print_verdict();
  end

endmodule

`default_nettype wire
